//--- slw_wakeup_timer.v
// Purpose: wake-up timer with prescaler, down counter, flag and RC calibration
// Assumes: slow ticks and register port synchronous to clk_sys
// Notes:   register reads answer one cycle after rd_en
//          0x316 prescale code in bits 2:0
//          0x317 wake arm in bit 0, clock source field in bits 6:3
//          0x318 reload low byte, 0x319 reload high byte
//          0x31a control: flag reset, calibration start, timer enable
//          0x31b status: calibration done, timeout flag, RC selected
//          0x31c, 0x31d timeout enable of line one and line two
//          0x31e live count low byte, also copies the high byte
//          0x31f high byte as copied by the last low byte read
//          unmapped reads return zero, unmapped writes are dropped
//          interrupt and wake outputs rise on the edge that sets the flag
//          disabling the timer freezes the count, enabling reloads it
`timescale 1ns/1ps
`include "slw_defs.vh"
module slw_wakeup_timer #(
  parameter CAL_CYCLES = `SLW_CAL_CYCLES
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        xtal_tick,
  input  wire        rc_tick,
  input  wire [10:0] reg_addr,
  input  wire        reg_wr_en,
  input  wire [7:0]  reg_wr_data,
  input  wire        reg_rd_en,
  output reg  [7:0]  reg_rd_data,
  input  wire        sleep_active,
  output reg         irq_one,
  output reg         irq_two,
  output reg         wake_up
);

  // ****************************************
  // software registers
  // ****************************************
  reg  [7:0]  timer_config_a_reg;
  reg  [7:0]  timer_config_b_reg;
  reg  [7:0]  reload_low_byte_reg;
  reg  [7:0]  reload_high_byte_reg;
  reg  [7:0]  timer_ctrl_reg;
  reg  [7:0]  irq_line_one_enable_reg;
  reg  [7:0]  irq_line_two_enable_reg;

  // ****************************************
  // timer state
  // ****************************************
  reg  [15:0] count_reg;
  reg  [15:0] count_next;
  reg         running_reg;
  reg         timeout_flag_reg;
  reg         timeout_flag_next;
  wire        flag_reset_bit;
  wire        flag_reset_fall;
  reg         flag_reset_prev_reg;
  wire        timer_enable;
  wire        enable_rise;
  wire        use_rc;
  wire        slow_tick;
  wire        prescaled_tick;
  wire [15:0] reload_value;
  wire        rc_calibration_done;
  wire [7:0]  slow_osc_status;
  wire        hit_zero;
  wire        count_step;
  wire        prescale_clear;
  wire [1:0]  line_enable;
  wire [1:0]  line_irq_next;
  wire        wake_next;
  reg  [7:0]  count_high_snap_reg;

  function slw_sel;
    input [10:0] addr;
    input [10:0] target;
    begin
      slw_sel = (addr == target);
    end
  endfunction

  // ****************************************
  // register writes
  // ****************************************
  // unmapped writes match no compare and are dropped
  always @(posedge clk_sys) begin
    if (reset) begin
      timer_config_a_reg      <= `SLW_RST_BYTE;
      timer_config_b_reg      <= `SLW_RST_BYTE;
      reload_low_byte_reg     <= `SLW_RST_BYTE;
      reload_high_byte_reg    <= `SLW_RST_BYTE;
      timer_ctrl_reg          <= `SLW_RST_BYTE;
      irq_line_one_enable_reg <= `SLW_RST_BYTE;
      irq_line_two_enable_reg <= `SLW_RST_BYTE;
    end else if (reg_wr_en) begin
      if (slw_sel(reg_addr, `SLW_ADDR_CFG_A)) begin
        timer_config_a_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_CFG_B)) begin
        timer_config_b_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_RELOAD_LO)) begin
        reload_low_byte_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_RELOAD_HI)) begin
        reload_high_byte_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_CTRL)) begin
        timer_ctrl_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_IRQ1_EN)) begin
        irq_line_one_enable_reg <= reg_wr_data;
      end
      if (slw_sel(reg_addr, `SLW_ADDR_IRQ2_EN)) begin
        irq_line_two_enable_reg <= reg_wr_data;
      end
    end
  end

  // ****************************************
  // clock source and prescaler
  // ****************************************
  assign use_rc    = timer_config_b_reg[`SLW_CFGB_SRC_RC];
  assign slow_tick = use_rc ? rc_tick : xtal_tick;
  assign timer_enable = timer_ctrl_reg[`SLW_CTRL_TMR_EN];
  assign enable_rise  = timer_enable && !running_reg;
  // a tick landing on the enable cycle is dropped with the count load
  assign prescale_clear = !timer_enable || enable_rise;

  // prescaler restarts with the counter so the first period is whole
  slw_prescaler u_prescaler (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clr       (prescale_clear),
    .slow_tick (slow_tick),
    .select    (timer_config_a_reg[`SLW_CFGA_PRESCALE]),
    .tick_out  (prescaled_tick)
  );

  // ****************************************
  // down counter
  // ****************************************
  assign reload_value = {reload_high_byte_reg, reload_low_byte_reg};
  assign count_step   = running_reg && prescaled_tick;

  // reload of zero times out on every prescaled tick
  always @* begin
    count_next = count_reg;
    if (enable_rise) begin
      count_next = reload_value;
    end else if (count_step) begin
      // periodic: after zero the next tick reloads
      if (count_reg == 16'h0000) begin
        count_next = reload_value;
      end else begin
        count_next = count_reg - 16'h0001;
      end
    end
  end

  assign hit_zero = count_step && (count_next == 16'h0000);

  // ****************************************
  // timeout flag
  // ****************************************
  // the flag outlives a disable: only the clear sequence drops it
  assign flag_reset_bit  = timer_ctrl_reg[`SLW_CTRL_FLAG_RST];
  // clear completes on the 1->0 step of the reset field
  assign flag_reset_fall = flag_reset_prev_reg && !flag_reset_bit;

  always @* begin
    timeout_flag_next = timeout_flag_reg;
    if (flag_reset_fall) begin
      timeout_flag_next = 1'b0;
    end
    // set after clear: a timeout in the clearing cycle is kept
    if (hit_zero) begin
      timeout_flag_next = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      count_reg           <= `SLW_RST_COUNT;
      running_reg         <= 1'b0;
      timeout_flag_reg    <= 1'b0;
      flag_reset_prev_reg <= 1'b0;
    end else begin
      count_reg           <= count_next;
      running_reg         <= timer_enable;
      timeout_flag_reg    <= timeout_flag_next;
      flag_reset_prev_reg <= flag_reset_bit;
    end
  end

  // ****************************************
  // interrupt lines
  // ****************************************
  // each line has its own mask so one host pin can stay quiet
  assign line_enable[0] = irq_line_one_enable_reg[`SLW_IRQ_TIMEOUT];
  assign line_enable[1] = irq_line_two_enable_reg[`SLW_IRQ_TIMEOUT];

  genvar line_idx;
  generate
    for (line_idx = 0; line_idx < 2; line_idx = line_idx + 1) begin : g_irq_line
      assign line_irq_next[line_idx] = timeout_flag_next && line_enable[line_idx];
    end
  endgenerate

  always @(posedge clk_sys) begin
    if (reset) begin
      irq_one <= 1'b0;
      irq_two <= 1'b0;
    end else begin
      irq_one <= line_irq_next[0];
      irq_two <= line_irq_next[1];
    end
  end

  // ****************************************
  // wake-up from sleep
  // ****************************************
  // level, not pulse: stands until the flag is cleared, sleep ends or the wake arm bit is cleared
  assign wake_next = timeout_flag_next && sleep_active &&
                     timer_config_b_reg[`SLW_CFGB_WAKE_ARM];

  always @(posedge clk_sys) begin
    if (reset) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= wake_next;
    end
  end

  // ****************************************
  // RC oscillator calibration
  // ****************************************
  // done drops on the edge after software clears the start bit
  slw_rc_cal #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_rc_cal (
    .clk_sys (clk_sys),
    .reset   (reset),
    .start   (timer_ctrl_reg[`SLW_CTRL_CAL_START]),
    .done    (rc_calibration_done)
  );

  // ****************************************
  // status byte and count readback
  // ****************************************
  // status bits are live; only the count high byte needs a copy
  assign slow_osc_status = {5'h00, use_rc, timeout_flag_reg, rc_calibration_done};

  // high byte is frozen by the low byte read, so a tick between
  // the two reads cannot tear the 16-bit value
  always @(posedge clk_sys) begin
    if (reset) begin
      count_high_snap_reg <= `SLW_RST_BYTE;
    end else if (reg_rd_en && slw_sel(reg_addr, `SLW_ADDR_COUNT_LO)) begin
      count_high_snap_reg <= count_reg[15:8];
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rd_data <= `SLW_RST_BYTE;
    end else if (reg_rd_en) begin
      case (reg_addr)
        `SLW_ADDR_CFG_A:     reg_rd_data <= timer_config_a_reg;
        `SLW_ADDR_CFG_B:     reg_rd_data <= timer_config_b_reg;
        `SLW_ADDR_RELOAD_LO: reg_rd_data <= reload_low_byte_reg;
        `SLW_ADDR_RELOAD_HI: reg_rd_data <= reload_high_byte_reg;
        `SLW_ADDR_CTRL:      reg_rd_data <= timer_ctrl_reg;
        `SLW_ADDR_STATUS:    reg_rd_data <= slow_osc_status;
        `SLW_ADDR_IRQ1_EN:   reg_rd_data <= irq_line_one_enable_reg;
        `SLW_ADDR_IRQ2_EN:   reg_rd_data <= irq_line_two_enable_reg;
        `SLW_ADDR_COUNT_LO:  reg_rd_data <= count_reg[7:0];
        `SLW_ADDR_COUNT_HI:  reg_rd_data <= count_high_snap_reg;
        default:             reg_rd_data <= `SLW_RST_BYTE;
      endcase
    end
  end

endmodule

//--- slw_defs.vh
// Purpose: shared constants of the sleep wake-up timer
// Assumes: byte wide register port, 11-bit register addresses
// Notes:   definitions only
`ifndef SLW_DEFS_VH
`define SLW_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define SLW_ADDR_CFG_A       11'h316
`define SLW_ADDR_CFG_B       11'h317
`define SLW_ADDR_RELOAD_LO   11'h318
`define SLW_ADDR_RELOAD_HI   11'h319
`define SLW_ADDR_CTRL        11'h31a
`define SLW_ADDR_STATUS      11'h31b
`define SLW_ADDR_IRQ1_EN     11'h31c
`define SLW_ADDR_IRQ2_EN     11'h31d
`define SLW_ADDR_COUNT_LO    11'h31e
`define SLW_ADDR_COUNT_HI    11'h31f

// ****************************************
// field positions
// ****************************************
`define SLW_CFGA_PRESCALE    2:0
`define SLW_CFGB_WAKE_ARM    0
`define SLW_CFGB_SRC_SEL     6:3
`define SLW_CFGB_SRC_RC      3
`define SLW_CTRL_FLAG_RST    0
`define SLW_CTRL_CAL_START   1
`define SLW_CTRL_TMR_EN      2
`define SLW_STAT_CAL_DONE    0
`define SLW_STAT_TIMEOUT     1
`define SLW_STAT_SRC_RC      2
`define SLW_IRQ_TIMEOUT      0

// ****************************************
// reset values
// ****************************************
`define SLW_RST_BYTE         8'h00
`define SLW_RST_COUNT        16'h0000

// ****************************************
// timing
// ****************************************
`define SLW_CLK_HZ           10000000
`define SLW_CAL_TIME_US      1000
`define SLW_CAL_CYCLES       ((`SLW_CAL_TIME_US * (`SLW_CLK_HZ / 1000)) / 1000)

`endif

//--- slw_prescaler.v
// Purpose: divides the selected slow tick by the programmed factor
// Assumes: slow_tick is a one-cycle pulse at 32.768 kHz rate
// Notes:   clr restarts the division from zero
`timescale 1ns/1ps
`include "slw_defs.vh"
module slw_prescaler (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire        clr,
  input  wire        slow_tick,
  input  wire [2:0]  select,
  output wire        tick_out
);

  reg  [15:0] div_cnt_reg;
  reg  [15:0] div_cnt_next;
  wire [15:0] terminal;

  // ****************************************
  // division factor minus one
  // ****************************************
  function [15:0] slw_div_terminal;
    input [2:0] sel;
    begin
      case (sel)
        3'h0:    slw_div_terminal = 16'h0000;
        3'h1:    slw_div_terminal = 16'h0003;
        3'h2:    slw_div_terminal = 16'h0007;
        3'h3:    slw_div_terminal = 16'h000f;
        3'h4:    slw_div_terminal = 16'h007f;
        3'h5:    slw_div_terminal = 16'h03ff;
        3'h6:    slw_div_terminal = 16'h1fff;
        default: slw_div_terminal = 16'hffff;
      endcase
    end
  endfunction

  assign terminal = slw_div_terminal(select);
  assign tick_out = slow_tick && (div_cnt_reg >= terminal);

  always @* begin
    div_cnt_next = div_cnt_reg;
    if (clr) begin
      div_cnt_next = `SLW_RST_COUNT;
    end else if (slow_tick) begin
      // >= so a smaller factor picked mid-count still ends promptly
      if (div_cnt_reg >= terminal) begin
        div_cnt_next = `SLW_RST_COUNT;
      end else begin
        div_cnt_next = div_cnt_reg + 16'h0001;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      div_cnt_reg <= `SLW_RST_COUNT;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

endmodule

//--- slw_rc_cal.v
// Purpose: times one calibration of the RC oscillator
// Assumes: start is the calibration control bit as software wrote it
// Notes:   done stays low while start is low
`timescale 1ns/1ps
`include "slw_defs.vh"
module slw_rc_cal #(
  parameter CAL_CYCLES = `SLW_CAL_CYCLES
) (
  input  wire clk_sys,
  input  wire reset,
  input  wire start,
  output reg  done
);

  localparam ST_IDLE = 3'b001;
  localparam ST_BUSY = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [15:0] cnt_reg;
  reg [15:0] cnt_next;
  reg        start_reg;
  wire       start_rise;

  // never runs on its own: only a fresh 0->1 starts it
  assign start_rise = start && !start_reg;

  always @* begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_rise) begin
          state_next = ST_BUSY;
          cnt_next   = 16'h0000;
        end
      end
      ST_BUSY: begin
        if (!start) begin
          state_next = ST_IDLE;
        end else if (cnt_reg == CAL_CYCLES[15:0] - 16'h0001) begin
          state_next = ST_DONE;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      ST_DONE: begin
        if (!start) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 16'h0000;
      start_reg <= 1'b0;
      done      <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      start_reg <= start;
      done      <= (state_next == ST_DONE);
    end
  end

endmodule

//--- slw_timer_monitor.sv
// Purpose: port checker for the wake-up timer
// Assumes: shadows of written fields track the design registers
// Notes:   bound to every timer instance
`timescale 1ns/1ps
`include "slw_defs.vh"
module slw_timer_monitor #(
  parameter CAL_CYCLES = 20
) (
  input wire        clk_sys,
  input wire        reset,
  input wire        xtal_tick,
  input wire        rc_tick,
  input wire [10:0] reg_addr,
  input wire        reg_wr_en,
  input wire [7:0]  reg_wr_data,
  input wire        reg_rd_en,
  input wire [7:0]  reg_rd_data,
  input wire        sleep_active,
  input wire        irq_one,
  input wire        irq_two,
  input wire        wake_up
);
  localparam int EARLY = CAL_CYCLES - 3;
  localparam int LATE  = CAL_CYCLES + 5;
  reg        en1_reg;
  reg        en2_reg;
  reg        arm_reg;
  reg        cal_reg;
  reg [1:0]  idle_reg;
  reg [15:0] run_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ****************************************
  // shadows
  // ****************************************
  always @(posedge clk_sys) begin
    if (reset) begin
      en1_reg  <= 1'b0;
      en2_reg  <= 1'b0;
      arm_reg  <= 1'b0;
      cal_reg  <= 1'b0;
      idle_reg <= 2'h3;
      run_reg  <= 16'h0000;
    end else begin
      if (reg_wr_en) begin
        case (reg_addr)
          `SLW_ADDR_IRQ1_EN: en1_reg <= reg_wr_data[0];
          `SLW_ADDR_IRQ2_EN: en2_reg <= reg_wr_data[0];
          `SLW_ADDR_CFG_B:   arm_reg <= reg_wr_data[0];
          `SLW_ADDR_CTRL:    cal_reg <= reg_wr_data[1];
          default: ;
        endcase
      end
      // saturate so a long idle or run never wraps
      idle_reg <= cal_reg ? 2'h0 : ((idle_reg == 2'h3) ? 2'h3 : idle_reg + 2'h1);
      run_reg  <= !cal_reg ? 16'h0000 : ((&run_reg) ? run_reg : run_reg + 16'h0001);
    end
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_stat_idle;
    reg_rd_en && reg_addr == `SLW_ADDR_STATUS && idle_reg == 2'h3;
  endsequence
  sequence s_stat_early;
    reg_rd_en && reg_addr == `SLW_ADDR_STATUS && cal_reg && run_reg < EARLY;
  endsequence
  sequence s_stat_late;
    reg_rd_en && reg_addr == `SLW_ADDR_STATUS && cal_reg && run_reg > LATE;
  endsequence
  a_rd_unmapped_zero: assert property (reg_rd_en && (reg_addr < `SLW_ADDR_CFG_A
    || reg_addr > `SLW_ADDR_COUNT_HI) |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_irq_one_mask: assert property (irq_one |-> $past(en1_reg))
    else $error("irq one while masked");
  a_irq_two_mask: assert property (irq_two |-> $past(en2_reg))
    else $error("irq two while masked");
  a_wake_needs_arm: assert property (wake_up |-> $past(sleep_active && arm_reg))
    else $error("wake without arm and sleep");
  a_wake_tracks_irq: assert property ($past(sleep_active && arm_reg && en1_reg)
    |-> wake_up == irq_one) else $error("wake differs from timeout");
  a_cal_idle_low: assert property (s_stat_idle |=> !reg_rd_data[0])
    else $error("cal ready while control low");
  a_cal_not_early: assert property (s_stat_early |=> !reg_rd_data[0])
    else $error("cal ready too early");
  a_cal_done_late: assert property (s_stat_late |=> reg_rd_data[0])
    else $error("cal ready too late");
endmodule

bind slw_wakeup_timer slw_timer_monitor #(.CAL_CYCLES(CAL_CYCLES)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .xtal_tick(xtal_tick), .rc_tick(rc_tick),
  .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
  .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .sleep_active(sleep_active),
  .irq_one(irq_one), .irq_two(irq_two), .wake_up(wake_up)
);

//--- slw_host_model.sv
// Purpose: host that configures the timer through its registers
// Assumes: one access at a time, strobes one cycle wide
// Notes:   keeps the host side of the setup and calibration order
`timescale 1ns/1ps
`include "slw_defs.vh"
module slw_host_model (
  input  wire        clk_sys,
  output reg  [10:0] reg_addr,
  output reg         reg_wr_en,
  output reg  [7:0]  reg_wr_data,
  output reg         reg_rd_en,
  input  wire [7:0]  reg_rd_data
);
  reg [7:0] ctrl_reg;
  initial begin
    reg_addr = 11'h000;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    ctrl_reg = 8'h00;
  end
  task wr(input [10:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d; // idle data must not look valid
  endtask
  task rd(input [10:0] a, output [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1 d = reg_rd_data;
  endtask
  task ctrl(input [7:0] v);
    ctrl_reg = v;
    wr(`SLW_ADDR_CTRL, v);
  endtask
  task setup(input rc, input [2:0] code, input [15:0] rl, input arm);
    ctrl(ctrl_reg & 8'h02); // a finished calibration survives the setup
    wr(`SLW_ADDR_CFG_B, {4'h0, rc, 3'h0});
    wr(`SLW_ADDR_RELOAD_LO, rl[7:0]);
    wr(`SLW_ADDR_RELOAD_HI, rl[15:8]);
    wr(`SLW_ADDR_CFG_A, {5'h00, code});
    ctrl(ctrl_reg | 8'h01);
    ctrl(ctrl_reg & 8'hfe);
    wr(`SLW_ADDR_CFG_B, {4'h0, rc, 2'h0, arm});
    ctrl(ctrl_reg | 8'h04);
  endtask
  task cal;
    ctrl(ctrl_reg & 8'hfd);
    ctrl(ctrl_reg | 8'h02);
  endtask
endmodule

//--- slw_tb.sv
// Purpose: self-checking bench for the wake-up timer
// Assumes: slow ticks are sped up, calibration shortened
// Notes:   count, flag and lines compared with a model after each tk, except the one of divide code 7
`timescale 1ns/1ps
`include "slw_defs.vh"
module tb;
  localparam CAL = 20;
  reg         clk_sys, reset, xtal_tick, rc_tick, sleep_active, m_rc, m_flag, m_en1, m_en2;
  reg         m_arm;
  reg  [31:0] rs;
  reg  [7:0]  lo, hi;
  wire [10:0] reg_addr;
  wire        reg_wr_en, reg_rd_en, irq_one, irq_two, wake_up;
  wire [7:0]  reg_wr_data, reg_rd_data;
  integer     errors, checked, m_cnt, m_rl, i, c, n;
  slw_wakeup_timer #(.CAL_CYCLES(CAL)) dut (.clk_sys(clk_sys), .reset(reset),
    .xtal_tick(xtal_tick), .rc_tick(rc_tick), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .sleep_active(sleep_active), .irq_one(irq_one), .irq_two(irq_two), .wake_up(wake_up));
  slw_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data));
  always #50 clk_sys = ~clk_sys;
  function logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task chk(input [15:0] got, input [15:0] exp, input [8*8-1:0] what);
    checked = checked + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("FAIL %0t %0s got %h want %h", $time, what, got, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ****************************************
  // stimulus and model
  // ****************************************
  task pulse; // the unselected source pulses too and must be ignored
    @(posedge clk_sys);
    rc_tick <= m_rc;
    xtal_tick <= !m_rc;
    @(posedge clk_sys);
    rc_tick <= !m_rc;
    xtal_tick <= m_rc;
    @(posedge clk_sys);
    rc_tick <= 1'b0;
    xtal_tick <= 1'b0;
  endtask
  task tk;
    pulse;
    m_cnt = (m_cnt == 0) ? m_rl : m_cnt - 1;
    if (m_cnt == 0) m_flag = 1'b1;
  endtask
  task sync;
    repeat (3) @(posedge clk_sys);
    #1 chk(irq_one, m_flag & m_en1, "irq1");
    chk(irq_two, m_flag & m_en2, "irq2");
    chk(wake_up, m_flag & m_arm & sleep_active, "wake");
    host.rd(`SLW_ADDR_STATUS, lo);
    chk(lo[2:1], {m_rc, m_flag}, "status");
    host.rd(`SLW_ADDR_COUNT_LO, lo);
    host.rd(`SLW_ADDR_COUNT_HI, hi);
    chk({hi, lo}, m_cnt[15:0], "count");
  endtask
  task cfg(input [2:0] code, input [15:0] rl, input arm);
    host.setup(m_rc, code, rl, arm);
    m_rl = rl;
    m_cnt = rl;
    m_flag = 1'b0;
    m_arm = arm;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors = errors + 1;
    $display("FAIL %0t watchdog expired", $time);
    conclude;
  end
  initial begin
    {clk_sys, xtal_tick, rc_tick, sleep_active, m_rc, m_en1, m_en2} = 7'h00;
    reset = 1'b1;
    errors = 0;
    checked = 0;
    rs = 44091;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    host.wr(11'h320, 8'hff);
    for (i = 'h316; i <= 'h320; i = i + 1) begin
      host.rd(i[10:0], lo);
      chk(lo, 8'h00, "reset");
    end
    $display("reset values done");
    for (c = 0; c < 8; c = c + 1) begin
      n = xs();
      m_rc = n[0];
      cfg(c[2:0], n[23:8] | 16'h0004, 1'b0);
      n = (c == 7) ? 100 : (c == 0) ? 1 : (c < 4) ? (2 << c) : (128 << (3 * (c - 4)));
      repeat (n - 1) pulse;
      sync;
      tk;
      if (c < 7) sync;
      $display("divide code %0d done", c);
    end
    m_rc = 1'b0;
    host.wr(`SLW_ADDR_IRQ1_EN, 8'h01);
    host.wr(`SLW_ADDR_IRQ2_EN, 8'h00);
    m_en1 = 1'b1;
    sleep_active <= 1'b1;
    cfg(3'h0, 16'h0002, 1'b1);
    for (i = 0; i < 7; i = i + 1) begin
      tk;
      sync;
    end
    @(posedge clk_sys);
    sleep_active <= 1'b0;
    sync;
    @(posedge clk_sys);
    sleep_active <= 1'b1;
    host.wr(`SLW_ADDR_CFG_B, 8'h00);
    m_arm = 1'b0;
    sync;
    host.wr(`SLW_ADDR_IRQ2_EN, 8'h01);
    m_en2 = 1'b1;
    sync;
    host.ctrl(8'h05);
    sync;
    host.ctrl(8'h04);
    m_flag = 1'b0;
    sync;
    host.wr(`SLW_ADDR_IRQ1_EN, 8'h00);
    m_en1 = 1'b0;
    tk;
    sync;
    $display("timeout flag done");
    host.cal;
    n = 0;
    lo = 8'h00;
    while (lo[0] !== 1'b1 && n < 60) begin
      host.rd(`SLW_ADDR_STATUS, lo);
      n = n + 2;
    end
    chk(n > CAL - 4 && n < CAL + 8, 1'b1, "caltime");
    repeat (10) @(posedge clk_sys);
    host.rd(`SLW_ADDR_STATUS, lo);
    chk(lo[0], 1'b1, "calhold");
    host.ctrl(8'h04);
    repeat (3) @(posedge clk_sys);
    host.rd(`SLW_ADDR_STATUS, lo);
    chk(lo[0], 1'b0, "caldrop");
    host.cal;
    host.rd(`SLW_ADDR_STATUS, lo);
    chk(lo[0], 1'b0, "calrun");
    $display("calibration done");
    conclude;
  end
endmodule
